// *** bench/nfcrt_ref_model.sv ***
// Model of the detection logic that feeds the reference value.
// Assumes it runs on the register clock and sits beside the bank.
`timescale 1ns/1ps
`default_nettype none

module nfcrt_ref_model #(
  parameter logic [7:0] ADC_REF = 8'h80
) (
  // Clock
  input wire logic i_clk,
  // Control
  input wire logic i_above,
  // Reference out
  output logic [7:0] o_ref
);
  // Tuned no-load value sits 5 either side of the ADC reference
  always_ff @(posedge i_clk) begin
    o_ref <= i_above ? ADC_REF + 8'h05 : ADC_REF - 8'h05;
  end
endmodule

`default_nettype wire

// *** bench/tb.sv ***
// Self-checking bench for the paged tuning register bank.
// Assumes the bank answers APB with its own pready; one 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module tb;
  localparam logic [7:0] ADC_REF = 8'h80;
  typedef struct packed {
    logic [7:0] page;
    logic [7:0] idx;
    logic [7:0] wd;
    logic [7:0] exp;
  } nfcrt_row_t;
  logic i_clk, i_reset_n, psel, penable, pwrite, above, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [7:0] ref_val;
  logic [1:0] c;
  nfcrt_pkg::nfcrt_cfg_t cfg;
  int n_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  nfcrt_row_t rows [10] = '{
    '{8'hAE, 8'h31, 8'hFF, 8'h3E}, '{8'hAE, 8'h32, 8'hA5, 8'hA5},
    '{8'hAE, 8'h33, 8'hFF, 8'h0C}, '{8'hAE, 8'h34, 8'hFF, 8'h3F},
    '{8'hAE, 8'h38, 8'h88, 8'h88}, '{8'hAE, 8'h39, 8'h3C, 8'h3C},
    '{8'hAE, 8'h3A, 8'hC3, 8'hC3}, '{8'hAE, 8'h3B, 8'h5A, 8'h5A},
    '{8'h00, 8'h3F, 8'hFF, 8'hFF}, '{8'h00, 8'h3E, 8'hFF, 8'h0F}};
  nfcrt_row_t rst_rows [10] = '{
    '{8'h00, 8'h3F, 8'h00, nfcrt_pkg::RST_SPECIAL},
    '{8'h00, 8'h3E, 8'h00, {4'h0, nfcrt_pkg::RST_DETECT_COUNT}},
    '{8'hAE, 8'h31, 8'h00, nfcrt_pkg::RST_ANALOG},
    '{8'hAE, 8'h32, 8'h00, nfcrt_pkg::RST_NOISE},
    '{8'hAE, 8'h33, 8'h00, nfcrt_pkg::RST_STEP},
    '{8'hAE, 8'h34, 8'h00, nfcrt_pkg::RST_AGC_MIN},
    '{8'hAE, 8'h38, 8'h00, nfcrt_pkg::RST_SC_DETECT_A},
    '{8'hAE, 8'h39, 8'h00, nfcrt_pkg::RST_SC_DETECT_B},
    '{8'hAE, 8'h3A, 8'h00, nfcrt_pkg::RST_START_BIT},
    '{8'hAE, 8'h3B, 8'h00, nfcrt_pkg::RST_GAIN_PREAMBLE}};
  logic [7:0] temps [4] = '{8'h00, nfcrt_pkg::TEMP_LIM_130,
    nfcrt_pkg::TEMP_LIM_140, nfcrt_pkg::TEMP_LIM_150};
  logic [9:0] spans [4] = '{nfcrt_pkg::ADC_SPAN_440, nfcrt_pkg::ADC_SPAN_520,
    nfcrt_pkg::ADC_SPAN_600, nfcrt_pkg::ADC_SPAN_680};

  nfcrt_regs DUT (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .i_pstrb(pstrb), .o_pready(pready),
    .o_prdata(prdata), .o_pslverr(pslverr),
    .i_detect_reference(ref_val), .o_cfg(cfg)
  );
  nfcrt_ref_model #(.ADC_REF(ADC_REF)) partner (
    .i_clk(i_clk), .i_above(above), .o_ref(ref_val)
  );

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic print_verdict();
    $display("Compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      print_verdict();
    end
  end

  // One APB transfer; result lands in rd and err
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [7:0] wd, input logic [3:0] st);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {4'h0, idx[5:0], 2'b00};
    pwdata <= {24'h00_0000, wd};
    pstrb <= st;
    @(posedge i_clk);
    penable <= 1'b1;
    // Values read here are those sampled at this rising edge
    do begin
      @(posedge i_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_errors++;
      $display("[ERR] %0t no pready", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge i_clk);
  endtask

  task automatic chk_bus(input logic [7:0] exp, input logic exp_err);
    n_compared++;
    if (rd !== {24'h00_0000, exp} || err !== exp_err) begin
      n_errors++;
      $display("[ERR] %0t read %h err %b, want %h %b", $time, rd, err,
               exp, exp_err);
    end
  endtask

  task automatic chk_cfg(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t config %h, want %h", $time, got, exp);
    end
  endtask

  task automatic page(input logic [7:0] code);
    apb(1'b1, nfcrt_pkg::IDX_PAGE_SEL, code, 4'h1);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp,
                        input logic exp_err);
    apb(1'b0, idx, 8'h00, 4'h0);
    chk_bus(exp, exp_err);
  endtask

  initial begin
    i_reset_n = 1'b0;
    {psel, penable, pwrite, above} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    repeat (3) @(posedge i_clk);
    i_reset_n <= 1'b1;
    @(posedge i_clk);
    foreach (rst_rows[i]) begin
      page(rst_rows[i].page);
      rd_chk(rst_rows[i].idx, rst_rows[i].exp, 1'b0);
    end
    foreach (rows[i]) begin
      page(rows[i].page);
      apb(1'b1, rows[i].idx, rows[i].wd, 4'h1);
      rd_chk(rows[i].idx, rows[i].exp, 1'b0);
    end
    for (int a = 0; a < 4; a++) begin
      c = 2'(a);
      apb(1'b1, nfcrt_pkg::IDX_SPECIAL, {2'b01, c, 2'b00, c[0], ~c[0]}, 4'h1);
      @(posedge i_clk);
      chk_cfg(32'(cfg.algo), 32'(c));
      chk_cfg(32'(cfg.rx_unit), c[0] ? 32'd64 : 32'd128);
      chk_cfg(32'(cfg.tx_unit), c[0] ? 32'd128 : 32'd64);
    end
    for (int n = 1; n < 16; n += 14) begin
      apb(1'b1, nfcrt_pkg::IDX_DETECT_COUNT, 8'(n), 4'h1);
      @(posedge i_clk);
      chk_cfg(32'(cfg.detect_window), 32'(n) * 16 * 4);
    end
    page(nfcrt_pkg::PAGE5_CODE);
    for (int a = 0; a < 4; a++) begin
      c = 2'(a);
      apb(1'b1, nfcrt_pkg::IDX_ANALOG, {2'b00, c[0], c, c, 1'b0}, 4'h1);
      @(posedge i_clk);
      chk_cfg(32'(cfg.temp_protect_on), 32'(!c[0]));
      chk_cfg(32'(cfg.temp_limit_c), 32'(temps[a]));
      chk_cfg(32'(cfg.adc_span_mv), 32'(spans[a]));
    end
    apb(1'b1, nfcrt_pkg::IDX_NOISE, 8'h10, 4'h1);
    apb(1'b1, nfcrt_pkg::IDX_SC_DETECT_A, 8'h88, 4'h1);
    apb(1'b1, nfcrt_pkg::IDX_STEP, 8'h08, 4'h1);
    @(posedge i_clk);
    chk_cfg(32'({cfg.psk_resync, cfg.filter_bypass, cfg.endcheck_on}),
            32'h0000_0006);
    chk_cfg(32'({cfg.n_edge, cfg.p_edge}), 32'h0000_0002);
    apb(1'b1, nfcrt_pkg::IDX_SC_DETECT_A, 8'h00, 4'h1);
    apb(1'b1, nfcrt_pkg::IDX_STEP, 8'h04, 4'h1);
    @(posedge i_clk);
    chk_cfg(32'({cfg.filter_bypass, cfg.endcheck_on}),
            32'h0000_0001);
    chk_cfg(32'({cfg.n_edge, cfg.p_edge}), 32'h0000_0001);
    apb(1'b1, nfcrt_pkg::IDX_NOISE, 8'h00, 4'h0);
    rd_chk(nfcrt_pkg::IDX_NOISE, 8'h10, 1'b0);
    rd_chk(nfcrt_pkg::IDX_SPECIAL, 8'h00, 1'b1);
    rd_chk(8'h20, 8'h00, 1'b1);
    // Reference settles two edges after the model moves
    above <= 1'b1;
    page(nfcrt_pkg::PAGE6_CODE);
    rd_chk(nfcrt_pkg::IDX_DETECT_REF, ADC_REF + 8'h05, 1'b0);
    apb(1'b1, nfcrt_pkg::IDX_DETECT_REF, 8'hFF, 4'h1);
    chk_cfg(32'(err), 32'h0000_0000);
    rd_chk(nfcrt_pkg::IDX_DETECT_REF, ADC_REF + 8'h05, 1'b0);
    above <= 1'b0;
    rd_chk(nfcrt_pkg::IDX_NOISE, 8'h00, 1'b1);
    rd_chk(nfcrt_pkg::IDX_DETECT_REF, ADC_REF - 8'h05, 1'b0);
    page(8'h00);
    rd_chk(nfcrt_pkg::IDX_ANALOG, 8'h00, 1'b1);
    i_reset_n <= 1'b0;
    @(posedge i_clk);
    i_reset_n <= 1'b1;
    @(posedge i_clk);
    rd_chk(nfcrt_pkg::IDX_SPECIAL, nfcrt_pkg::RST_SPECIAL, 1'b0);
    chk_cfg(32'(cfg.rx_unit), 32'd128);
    print_verdict();
  end
endmodule

`default_nettype wire

// *** src/nfcrt_pkg.sv ***
// Package for the reader tuning register bank: indices, fields, resets,
// page codes, register ids and the decoded configuration carrier.
// Assumes one 100 MHz register clock; byte address is four times the index.
package nfcrt_pkg;

  // Register indices (byte address = index * 4)
  localparam logic [7:0] IDX_PAGE_SEL = 8'h00;
  localparam logic [7:0] IDX_DETECT_COUNT = 8'h3E;
  localparam logic [7:0] IDX_SPECIAL = 8'h3F;
  localparam logic [7:0] IDX_ANALOG = 8'h31;
  localparam logic [7:0] IDX_NOISE = 8'h32;
  localparam logic [7:0] IDX_STEP = 8'h33;
  localparam logic [7:0] IDX_AGC_MIN = 8'h34;
  localparam logic [7:0] IDX_SC_DETECT_A = 8'h38;
  localparam logic [7:0] IDX_SC_DETECT_B = 8'h39;
  localparam logic [7:0] IDX_START_BIT = 8'h3A;
  localparam logic [7:0] IDX_GAIN_PREAMBLE = 8'h3B;
  localparam logic [7:0] IDX_DETECT_REF = 8'h31;

  // Page select codes
  localparam logic [7:0] PAGE5_CODE = 8'hAE;
  localparam logic [7:0] PAGE6_CODE = 8'h5A;

  // Reset values
  localparam logic [7:0] RST_PAGE_SEL = 8'h00;
  localparam logic [3:0] RST_DETECT_COUNT = 4'h4;
  localparam logic [7:0] RST_SPECIAL = 8'h50;
  localparam logic [7:0] RST_ANALOG = 8'h14;
  localparam logic [7:0] RST_NOISE = 8'h7D;
  localparam logic [7:0] RST_STEP = 8'h00;
  localparam logic [7:0] RST_AGC_MIN = 8'h10;
  localparam logic [7:0] RST_SC_DETECT_A = 8'h76;
  localparam logic [7:0] RST_SC_DETECT_B = 8'h56;
  localparam logic [7:0] RST_START_BIT = 8'h31;
  localparam logic [7:0] RST_GAIN_PREAMBLE = 8'h12;
  localparam logic [7:0] RST_DETECT_REF = 8'h00;

  // Writable bit masks; other bits read as zero
  localparam logic [7:0] ANALOG_WMASK = 8'h3E;
  localparam logic [7:0] STEP_WMASK = 8'h0C;
  localparam logic [7:0] AGC_MIN_WMASK = 8'h3F;

  // Field positions
  localparam int SPC_ALGO_LSB = 4;
  localparam int SPC_RX_UNIT_BIT = 1;
  localparam int SPC_TX_UNIT_BIT = 0;
  localparam int ANA_TEMP_OFF_BIT = 5;
  localparam int ANA_TEMP_LIM_LSB = 3;
  localparam int ANA_ADC_RANGE_LSB = 1;
  localparam int NOI_PSK_RESYNC_BIT = 4;
  localparam int STP_N_EDGE_BIT = 3;
  localparam int STP_P_EDGE_BIT = 2;
  localparam int SCA_FILTER_OFF_BIT = 7;
  localparam int SCA_ENDCHECK_OFF_BIT = 3;

  // Timing units in carrier cycles, detection window multipliers
  localparam logic [7:0] ETU_SLOW_CYCLES = 8'h80;
  localparam logic [7:0] ETU_FAST_CYCLES = 8'h40;
  localparam logic [9:0] DETECT_SWING_MUL = 10'h010;
  localparam logic [9:0] DETECT_PHASE_MUL = 10'h004;

  // Temperature limits in degrees C, ADC spans in mV
  localparam logic [7:0] TEMP_LIM_130 = 8'h82;
  localparam logic [7:0] TEMP_LIM_140 = 8'h8C;
  localparam logic [7:0] TEMP_LIM_150 = 8'h96;
  localparam logic [9:0] ADC_SPAN_440 = 10'h1B8;
  localparam logic [9:0] ADC_SPAN_520 = 10'h208;
  localparam logic [9:0] ADC_SPAN_600 = 10'h258;
  localparam logic [9:0] ADC_SPAN_680 = 10'h2A8;

  typedef enum logic [1:0] {
    ALGO_AUTO, ALGO_ONE, ALGO_TWO, ALGO_UNDEF
  } nfcrt_algo_t;

  typedef enum logic [3:0] {
    RID_NONE, RID_PAGE, RID_DETCNT, RID_SPECIAL, RID_ANALOG, RID_NOISE,
    RID_STEP, RID_AGC, RID_SCA, RID_SCB, RID_START, RID_GAIN, RID_REF
  } nfcrt_rid_t;

  typedef struct packed {
    logic [9:0] detect_window;
    logic [7:0] rx_unit;
    logic [7:0] tx_unit;
    nfcrt_algo_t algo;
    logic temp_protect_on;
    logic [7:0] temp_limit_c;
    logic [9:0] adc_span_mv;
    logic psk_resync;
    logic filter_bypass;
    logic endcheck_on;
    logic n_edge;
    logic p_edge;
  } nfcrt_cfg_t;

endpackage

// *** src/nfcrt_regs.sv ***
// Paged tuning register bank of the reader front end, APB slave.
// Assumes i_detect_reference comes from detection logic on i_clk.
// Notes on behaviour
// - Detection window is count times 16 times 4 detection-clock periods.
// - Receive wait unit is 128 carrier cycles, or 64 when select is set.
// - Transmit wait unit is 128 carrier cycles, or 64 when select is set.
// - Algorithm select: 00 auto, 01 first, 10 second, 11 undefined.
// - Overtemperature protection is on when control bit is 0.
// - Threshold 01 is 130, 10 is 140, 11 is 150 degrees; 00 undefined.
// - ADC span codes 00 to 11 give 440, 520, 600, 680 mV.
// - Resync bit set makes demodulator resync after each PSK character.
// - High-rate filter disable bit set bypasses the subcarrier filter.
// - End-check disable bit clear enables subcarrier end detection.
// - N-side edge bit shapes A/B modulation edges on N driver.
// - P-side edge bit shapes A/B modulation edges on P driver.
// - Page-six reference value is read-only and resets to zero.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module nfcrt_regs (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  // Detection logic
  input wire logic [7:0] i_detect_reference,
  // Decoded configuration
  output nfcrt_pkg::nfcrt_cfg_t o_cfg
);

  typedef struct packed {
    logic [7:0] page_select;
    logic [3:0] detect_count;
    logic [7:0] special;
    logic [7:0] analog;
    logic [7:0] noise;
    logic [7:0] step;
    logic [7:0] agc_min;
    logic [7:0] sc_detect_a;
    logic [7:0] sc_detect_b;
    logic [7:0] start_bit;
    logic [7:0] gain_preamble;
    logic [7:0] detect_ref;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    nfcrt_pkg::nfcrt_cfg_t cfg;
  } nfcrt_state_t;

  nfcrt_state_t st_reg;
  nfcrt_state_t st_next;
  nfcrt_pkg::nfcrt_rid_t rid;
  logic access;
  logic commit;

  // Page-aware address decode
  function automatic nfcrt_pkg::nfcrt_rid_t reg_decode(
    input logic [11:0] addr,
    input logic [7:0] page
  );
    logic [7:0] idx;
    nfcrt_pkg::nfcrt_rid_t r;
    idx = {2'b00, addr[7:2]};
    r = nfcrt_pkg::RID_NONE;
    if (addr[1:0] == 2'b00 && addr[11:8] == 4'h0) begin
      if (idx == nfcrt_pkg::IDX_PAGE_SEL) begin
        r = nfcrt_pkg::RID_PAGE;
      end else if (page == nfcrt_pkg::PAGE5_CODE) begin
        case (idx)
          nfcrt_pkg::IDX_ANALOG: r = nfcrt_pkg::RID_ANALOG;
          nfcrt_pkg::IDX_NOISE: r = nfcrt_pkg::RID_NOISE;
          nfcrt_pkg::IDX_STEP: r = nfcrt_pkg::RID_STEP;
          nfcrt_pkg::IDX_AGC_MIN: r = nfcrt_pkg::RID_AGC;
          nfcrt_pkg::IDX_SC_DETECT_A: r = nfcrt_pkg::RID_SCA;
          nfcrt_pkg::IDX_SC_DETECT_B: r = nfcrt_pkg::RID_SCB;
          nfcrt_pkg::IDX_START_BIT: r = nfcrt_pkg::RID_START;
          nfcrt_pkg::IDX_GAIN_PREAMBLE: r = nfcrt_pkg::RID_GAIN;
          default: r = nfcrt_pkg::RID_NONE;
        endcase
      end else if (page == nfcrt_pkg::PAGE6_CODE) begin
        if (idx == nfcrt_pkg::IDX_DETECT_REF) begin
          r = nfcrt_pkg::RID_REF;
        end
      end else begin
        case (idx)
          nfcrt_pkg::IDX_SPECIAL: r = nfcrt_pkg::RID_SPECIAL;
          nfcrt_pkg::IDX_DETECT_COUNT: r = nfcrt_pkg::RID_DETCNT;
          default: r = nfcrt_pkg::RID_NONE;
        endcase
      end
    end
    return r;
  endfunction

  always_comb begin
    st_next = st_reg;
    rid = reg_decode(i_paddr, st_reg.page_select);
    access = i_psel && i_penable;
    commit = access && st_reg.pready;
    // Reference value follows detection logic only
    st_next.detect_ref = i_detect_reference;
    if (access && !st_reg.pready) begin
      // One wait state: read data and error prepared here
      st_next.pready = 1'b1;
      st_next.pslverr = (rid == nfcrt_pkg::RID_NONE);
      st_next.prdata = 32'h0000_0000;
      case (rid)
        nfcrt_pkg::RID_PAGE: st_next.prdata[7:0] = st_reg.page_select;
        nfcrt_pkg::RID_DETCNT: st_next.prdata[3:0] = st_reg.detect_count;
        nfcrt_pkg::RID_SPECIAL: st_next.prdata[7:0] = st_reg.special;
        nfcrt_pkg::RID_ANALOG: st_next.prdata[7:0] = st_reg.analog;
        nfcrt_pkg::RID_NOISE: st_next.prdata[7:0] = st_reg.noise;
        nfcrt_pkg::RID_STEP: st_next.prdata[7:0] = st_reg.step;
        nfcrt_pkg::RID_AGC: st_next.prdata[7:0] = st_reg.agc_min;
        nfcrt_pkg::RID_SCA: st_next.prdata[7:0] = st_reg.sc_detect_a;
        nfcrt_pkg::RID_SCB: st_next.prdata[7:0] = st_reg.sc_detect_b;
        nfcrt_pkg::RID_START: st_next.prdata[7:0] = st_reg.start_bit;
        nfcrt_pkg::RID_GAIN: st_next.prdata[7:0] = st_reg.gain_preamble;
        nfcrt_pkg::RID_REF: st_next.prdata[7:0] = st_reg.detect_ref;
        default: st_next.prdata = 32'h0000_0000;
      endcase
    end else if (commit) begin
      st_next.pready = 1'b0;
      st_next.pslverr = 1'b0;
      st_next.prdata = 32'h0000_0000;
      if (i_pwrite && i_pstrb[0]) begin
        case (rid)
          nfcrt_pkg::RID_PAGE: st_next.page_select = i_pwdata[7:0];
          nfcrt_pkg::RID_DETCNT: st_next.detect_count = i_pwdata[3:0];
          nfcrt_pkg::RID_SPECIAL: st_next.special = i_pwdata[7:0];
          nfcrt_pkg::RID_ANALOG:
            st_next.analog = i_pwdata[7:0] & nfcrt_pkg::ANALOG_WMASK;
          nfcrt_pkg::RID_NOISE: st_next.noise = i_pwdata[7:0];
          nfcrt_pkg::RID_STEP:
            st_next.step = i_pwdata[7:0] & nfcrt_pkg::STEP_WMASK;
          nfcrt_pkg::RID_AGC:
            st_next.agc_min = i_pwdata[7:0] & nfcrt_pkg::AGC_MIN_WMASK;
          nfcrt_pkg::RID_SCA: st_next.sc_detect_a = i_pwdata[7:0];
          nfcrt_pkg::RID_SCB: st_next.sc_detect_b = i_pwdata[7:0];
          nfcrt_pkg::RID_START: st_next.start_bit = i_pwdata[7:0];
          nfcrt_pkg::RID_GAIN: st_next.gain_preamble = i_pwdata[7:0];
          default: st_next.page_select = st_reg.page_select;
        endcase
      end
    end

    // Decoded configuration
    st_next.cfg.detect_window = 10'(st_reg.detect_count)
      * nfcrt_pkg::DETECT_SWING_MUL * nfcrt_pkg::DETECT_PHASE_MUL;
    st_next.cfg.rx_unit = st_reg.special[nfcrt_pkg::SPC_RX_UNIT_BIT] ?
      nfcrt_pkg::ETU_FAST_CYCLES : nfcrt_pkg::ETU_SLOW_CYCLES;
    st_next.cfg.tx_unit = st_reg.special[nfcrt_pkg::SPC_TX_UNIT_BIT] ?
      nfcrt_pkg::ETU_FAST_CYCLES : nfcrt_pkg::ETU_SLOW_CYCLES;
    case (st_reg.special[nfcrt_pkg::SPC_ALGO_LSB +: 2])
      2'b00: st_next.cfg.algo = nfcrt_pkg::ALGO_AUTO;
      2'b01: st_next.cfg.algo = nfcrt_pkg::ALGO_ONE;
      2'b10: st_next.cfg.algo = nfcrt_pkg::ALGO_TWO;
      default: st_next.cfg.algo = nfcrt_pkg::ALGO_UNDEF;
    endcase
    st_next.cfg.temp_protect_on =
      !st_reg.analog[nfcrt_pkg::ANA_TEMP_OFF_BIT];
    case (st_reg.analog[nfcrt_pkg::ANA_TEMP_LIM_LSB +: 2])
      2'b01: st_next.cfg.temp_limit_c = nfcrt_pkg::TEMP_LIM_130;
      2'b10: st_next.cfg.temp_limit_c = nfcrt_pkg::TEMP_LIM_140;
      2'b11: st_next.cfg.temp_limit_c = nfcrt_pkg::TEMP_LIM_150;
      default: st_next.cfg.temp_limit_c = 8'h00;
    endcase
    case (st_reg.analog[nfcrt_pkg::ANA_ADC_RANGE_LSB +: 2])
      2'b00: st_next.cfg.adc_span_mv = nfcrt_pkg::ADC_SPAN_440;
      2'b01: st_next.cfg.adc_span_mv = nfcrt_pkg::ADC_SPAN_520;
      2'b10: st_next.cfg.adc_span_mv = nfcrt_pkg::ADC_SPAN_600;
      default: st_next.cfg.adc_span_mv = nfcrt_pkg::ADC_SPAN_680;
    endcase
    st_next.cfg.psk_resync =
      st_reg.noise[nfcrt_pkg::NOI_PSK_RESYNC_BIT];
    st_next.cfg.filter_bypass =
      st_reg.sc_detect_a[nfcrt_pkg::SCA_FILTER_OFF_BIT];
    st_next.cfg.endcheck_on =
      !st_reg.sc_detect_a[nfcrt_pkg::SCA_ENDCHECK_OFF_BIT];
    st_next.cfg.n_edge = st_reg.step[nfcrt_pkg::STP_N_EDGE_BIT];
    st_next.cfg.p_edge = st_reg.step[nfcrt_pkg::STP_P_EDGE_BIT];
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_reg.page_select <= nfcrt_pkg::RST_PAGE_SEL;
      st_reg.detect_count <= nfcrt_pkg::RST_DETECT_COUNT;
      st_reg.special <= nfcrt_pkg::RST_SPECIAL;
      st_reg.analog <= nfcrt_pkg::RST_ANALOG;
      st_reg.noise <= nfcrt_pkg::RST_NOISE;
      st_reg.step <= nfcrt_pkg::RST_STEP;
      st_reg.agc_min <= nfcrt_pkg::RST_AGC_MIN;
      st_reg.sc_detect_a <= nfcrt_pkg::RST_SC_DETECT_A;
      st_reg.sc_detect_b <= nfcrt_pkg::RST_SC_DETECT_B;
      st_reg.start_bit <= nfcrt_pkg::RST_START_BIT;
      st_reg.gain_preamble <= nfcrt_pkg::RST_GAIN_PREAMBLE;
      st_reg.detect_ref <= nfcrt_pkg::RST_DETECT_REF;
      st_reg.pready <= 1'b0;
      st_reg.pslverr <= 1'b0;
      st_reg.prdata <= 32'h0000_0000;
      st_reg.cfg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_pready = st_reg.pready;
  assign o_prdata = st_reg.prdata;
  assign o_pslverr = st_reg.pslverr;
  assign o_cfg = st_reg.cfg;

  a_detect_window: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    i_reset_n && $past(i_reset_n) |->
      o_cfg.detect_window == 10'($past(st_reg.detect_count)) * 10'd64)
    else $error("detection window not count times 64");

  a_rx_unit_fast: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    i_reset_n && st_reg.special[1] |=> o_cfg.rx_unit == 8'd64)
    else $error("receive wait unit not 64 cycles");

  a_tx_unit_slow: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    i_reset_n && !st_reg.special[0] |=> o_cfg.tx_unit == 8'd128)
    else $error("transmit wait unit not 128 cycles");

  a_algo_two_sel: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    i_reset_n && st_reg.special[5:4] == 2'b10
      |=> o_cfg.algo == nfcrt_pkg::ALGO_TWO)
    else $error("algorithm two not selected");

  a_temp_protect_on: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    i_reset_n && $fell(st_reg.analog[5]) |=> o_cfg.temp_protect_on)
    else $error("protection not on after bit cleared");

  a_temp_limit_150: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    i_reset_n && st_reg.analog[4:3] == 2'b11
      |=> o_cfg.temp_limit_c == 8'd150)
    else $error("temperature limit not 150");

  a_adc_span_440: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    i_reset_n && st_reg.analog[2:1] == 2'b00
      |=> o_cfg.adc_span_mv == 10'd440)
    else $error("ADC span not 440 mV");

  a_ref_read_only: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    i_psel && i_penable && i_pwrite |=>
      st_reg.detect_ref == $past(i_detect_reference))
    else $error("reference value changed by a write");

  a_analog_paged_write: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    commit && i_pwrite && i_pstrb[0] && rid == nfcrt_pkg::RID_ANALOG
      |=> st_reg.analog == ($past(i_pwdata[7:0]) & nfcrt_pkg::ANALOG_WMASK)
        && $stable(st_reg.noise))
    else $error("page five write did not land in analog register");

  a_page6_no_analog: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    st_reg.page_select == nfcrt_pkg::PAGE6_CODE && commit
      |=> $stable(st_reg.analog))
    else $error("page six access altered page five storage");

  a_apb_one_wait: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    i_psel && i_penable && !o_pready |=> o_pready ##1 !o_pready)
    else $error("APB answer not after one wait state");

endmodule

`default_nettype wire
